//--- logic/csrr_pkg.sv
`default_nettype none
package csrr_pkg;
  // Bus geometry. Register indices are word indices; byte address is four times the index.
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned REG_W = 9;
  localparam int unsigned LVL_W = 9;
  localparam int unsigned EV_W = 5;

  // Register indices.
  localparam logic [7:0] IDX_BIAS = 8'h4B;
  localparam logic [7:0] IDX_PTP = 8'h4C;
  localparam logic [7:0] IDX_PEAK = 8'h4D;
  localparam logic [7:0] IDX_AMUTE = 8'h4E;
  localparam logic [7:0] IDX_TIEOFF = 8'h4F;
  localparam logic [7:0] IDX_IRQ_STS = 8'h50;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h51;

  // Field positions in the automute control and status register.
  localparam int unsigned AMUTE_TAP_BIT = 5;
  localparam int unsigned HV_BIT = 4;
  localparam int unsigned NG_BIT = 3;
  localparam int unsigned AMF_BIT = 2;
  localparam int unsigned DML_BIT = 1;
  localparam int unsigned DMR_BIT = 0;

  // Field positions in the output tie-off and bias registers.
  localparam int unsigned OVR_EN_BIT = 8;
  localparam int unsigned HBUF_BIT = 7;
  localparam int unsigned LBUF_BIT = 6;
  localparam int unsigned VREFL_BIT = 0;

  // Event status and mask share the layout of bits 4:0 of the automute register.
  localparam logic [EV_W-1:0] EV_RST = 5'h00;
  localparam logic [REG_W-1:0] REG_RST = 9'h000;

  function automatic logic [ADDR_W-1:0] csrr_addr(input logic [7:0] idx);
    csrr_addr = {idx, 2'h0};
  endfunction : csrr_addr

  // Both channels under level control report the larger one; otherwise the controlled one, or the left one when neither is.
  function automatic logic [LVL_W-1:0] csrr_lvl_max(input logic [LVL_W-1:0] l,
                                                    input logic [LVL_W-1:0] r,
                                                    input logic l_en,
                                                    input logic r_en);
    if (l_en && r_en) begin
      csrr_lvl_max = (l > r) ? l : r;
    end else if (r_en) begin
      csrr_lvl_max = r;
    end else begin
      csrr_lvl_max = l;
    end
  endfunction : csrr_lvl_max
endpackage : csrr_pkg
`default_nettype wire

//--- logic/csrr_lvl_if.sv
`default_nettype none
interface csrr_lvl_if;
  logic [8:0] ptp_l;
  logic [8:0] ptp_r;
  logic [8:0] pk_l;
  logic [8:0] pk_r;
  logic alc_l;
  logic alc_r;
  logic [8:0] ptp_sel;
  logic [8:0] pk_sel;

  modport src (
    output ptp_l, ptp_r, pk_l, pk_r, alc_l, alc_r,
    input ptp_sel, pk_sel
  );

  modport pick (
    input ptp_l, ptp_r, pk_l, pk_r, alc_l, alc_r,
    output ptp_sel, pk_sel
  );
endinterface : csrr_lvl_if
`default_nettype wire

//--- logic/csrr_level_pick.sv
`default_nettype none
module csrr_level_pick (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Level sources and picked readouts
  csrr_lvl_if.pick lvl
);
  import csrr_pkg::*;

  typedef struct packed {
    logic [LVL_W-1:0] ptp;
    logic [LVL_W-1:0] pk;
  } csrr_pick_state_type;

  csrr_pick_state_type state_ff;
  csrr_pick_state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ptp = csrr_lvl_max(lvl.ptp_l, lvl.ptp_r, lvl.alc_l, lvl.alc_r);
    nxt_state.pk = csrr_lvl_max(lvl.pk_l, lvl.pk_r, lvl.alc_l, lvl.alc_r);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= '{ptp: 9'h000, pk: 9'h000};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign lvl.ptp_sel = state_ff.ptp;
  assign lvl.pk_sel = state_ff.pk;

  default clocking pick_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ptp_max_a: assert property ((lvl.alc_l && lvl.alc_r) |=>
    lvl.ptp_sel == (($past(lvl.ptp_l) > $past(lvl.ptp_r)) ? $past(lvl.ptp_l) : $past(lvl.ptp_r)))
    else $error("peak-to-peak readout is not the larger channel");

  pk_max_a: assert property ((lvl.alc_l && lvl.alc_r) |=>
    lvl.pk_sel == (($past(lvl.pk_l) > $past(lvl.pk_r)) ? $past(lvl.pk_l) : $past(lvl.pk_r)))
    else $error("peak readout is not the larger channel");

  both_alc_c: cover property (lvl.alc_l && lvl.alc_r && (lvl.ptp_r > lvl.ptp_l));
endmodule : csrr_level_pick
`default_nettype wire

//--- logic/csrr_regs.sv
// Our own choice: register access over Avalon-MM.
`default_nettype none
// Functional notes
// - Peak-to-peak readout register shows the live peak-to-peak level value.
// - Peak detector readout register shows the live peak detector level value.
// - With both channels under level control, readouts report the larger channel.
// - Automute tap select: 0 watches attenuator input, 1 watches serial DAC input.
// - High supply detect bit reads 1 at about 4.0 V or above.
// - Noise gate bit reads 1 while signal is below threshold and gain frozen.
// - Analog mute flag reads 1 while the DAC channels are automuted.
// - Each digital mute flag reads 1 while that channel's digital gain is zero.
// - Override enable lets manual tie-off bits add closures to automatic control; cleared, they are ignored.
// - Under override, high buffer bypass closes its switch while that buffer is off.
// - Under override, low buffer bypass closes its switch while that buffer is off.
// - Vref low-ohm force closes its switch; cleared, power management decides.
module csrr_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [csrr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [csrr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [csrr_pkg::BE_W-1:0] avs_byteenable,
  output logic [csrr_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Level control values from the ALC core
  input wire logic [csrr_pkg::LVL_W-1:0] peak_to_peak_level_left,
  input wire logic [csrr_pkg::LVL_W-1:0] peak_to_peak_level_right,
  input wire logic [csrr_pkg::LVL_W-1:0] peak_detect_level_left,
  input wire logic [csrr_pkg::LVL_W-1:0] peak_detect_level_right,
  input wire logic alc_left_en,
  input wire logic alc_right_en,
  // Status sources
  input wire logic high_supply_detect_pin,
  input wire logic noise_gate_active,
  input wire logic analog_mute_flag,
  input wire logic left_digital_mute_flag,
  input wire logic right_digital_mute_flag,
  // Tie-off switch sources
  input wire logic high_buf_disabled,
  input wire logic low_buf_disabled,
  input wire logic high_buf_bypass_auto,
  input wire logic low_buf_bypass_auto,
  input wire logic vref_low_ohm_pm,
  // Controls to the analog and DAC paths
  output logic automute_tap_select,
  output logic high_buf_bypass_sw,
  output logic low_buf_bypass_sw,
  output logic vref_low_ohm_sw,
  // Interrupt
  output logic irq
);
  import csrr_pkg::*;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
    logic amute_sel;
    logic ovr_en;
    logic hbuf;
    logic lbuf;
    logic vref_force;
    logic hv_s1;
    logic hv_s2;
    logic [EV_W-1:0] flags_prev;
    logic [EV_W-1:0] irq_sts;
    logic [EV_W-1:0] irq_msk;
    logic irq;
    logic hbuf_sw;
    logic lbuf_sw;
    logic vref_sw;
  } csrr_regs_state_type;

  localparam csrr_regs_state_type STATE_RST = '{
    waitrequest: 1'h1,
    readdata: 32'h0000_0000,
    flags_prev: EV_RST,
    irq_sts: EV_RST,
    irq_msk: EV_RST,
    default: 1'h0
  };

  csrr_regs_state_type state_ff;
  csrr_regs_state_type nxt_state;

  csrr_lvl_if lvl_bus ();

  logic req;
  logic acc;
  logic wr_go;
  logic lane0;
  logic lane1;
  logic [EV_W-1:0] flags;
  logic [EV_W-1:0] rise;
  logic [EV_W-1:0] clr;
  logic [REG_W-1:0] rd_val;

  assign lvl_bus.ptp_l = peak_to_peak_level_left;
  assign lvl_bus.ptp_r = peak_to_peak_level_right;
  assign lvl_bus.pk_l = peak_detect_level_left;
  assign lvl_bus.pk_r = peak_detect_level_right;
  assign lvl_bus.alc_l = alc_left_en;
  assign lvl_bus.alc_r = alc_right_en;

  csrr_level_pick u_pick (
    .mclk(mclk),
    .rst(rst),
    .lvl(lvl_bus)
  );

  always_comb begin
    nxt_state = state_ff;
    req = avs_read | avs_write;
    // A request is latched while waitrequest is high and completes on the next edge.
    acc = req & state_ff.waitrequest;
    wr_go = avs_write & ~state_ff.waitrequest;
    lane0 = avs_byteenable[0];
    lane1 = avs_byteenable[1];
    clr = EV_RST;

    // The supply comparator is asynchronous to mclk.
    nxt_state.hv_s1 = high_supply_detect_pin;
    nxt_state.hv_s2 = state_ff.hv_s1;

    flags = EV_RST;
    flags[HV_BIT] = state_ff.hv_s2;
    flags[NG_BIT] = noise_gate_active;
    flags[AMF_BIT] = analog_mute_flag;
    flags[DML_BIT] = left_digital_mute_flag;
    flags[DMR_BIT] = right_digital_mute_flag;
    nxt_state.flags_prev = flags;
    rise = flags & ~state_ff.flags_prev;

    rd_val = REG_RST;
    if (avs_address == csrr_addr(IDX_BIAS)) begin
      rd_val[VREFL_BIT] = state_ff.vref_force;
    end else if (avs_address == csrr_addr(IDX_PTP)) begin
      rd_val = lvl_bus.ptp_sel;
    end else if (avs_address == csrr_addr(IDX_PEAK)) begin
      rd_val = lvl_bus.pk_sel;
    end else if (avs_address == csrr_addr(IDX_AMUTE)) begin
      rd_val[EV_W-1:0] = flags;
      rd_val[AMUTE_TAP_BIT] = state_ff.amute_sel;
    end else if (avs_address == csrr_addr(IDX_TIEOFF)) begin
      rd_val[OVR_EN_BIT] = state_ff.ovr_en;
      rd_val[HBUF_BIT] = state_ff.hbuf;
      rd_val[LBUF_BIT] = state_ff.lbuf;
    end else if (avs_address == csrr_addr(IDX_IRQ_STS)) begin
      rd_val[EV_W-1:0] = state_ff.irq_sts;
    end else if (avs_address == csrr_addr(IDX_IRQ_MSK)) begin
      rd_val[EV_W-1:0] = state_ff.irq_msk;
    end

    nxt_state.waitrequest = ~acc;
    if (acc) begin
      // Upper data bits are reserved and read as zero; reading alters no state.
      nxt_state.readdata = avs_read ? {{(DATA_W-REG_W){1'h0}}, rd_val} : 32'h0000_0000;
    end

    if (wr_go) begin
      if (avs_address == csrr_addr(IDX_BIAS)) begin
        if (lane0) begin
          nxt_state.vref_force = avs_writedata[VREFL_BIT];
        end
      end else if (avs_address == csrr_addr(IDX_AMUTE)) begin
        // Only the tap select is writable; the status flags ignore writes.
        if (lane0) begin
          nxt_state.amute_sel = avs_writedata[AMUTE_TAP_BIT];
        end
      end else if (avs_address == csrr_addr(IDX_TIEOFF)) begin
        if (lane1) begin
          nxt_state.ovr_en = avs_writedata[OVR_EN_BIT];
        end
        if (lane0) begin
          nxt_state.hbuf = avs_writedata[HBUF_BIT];
          nxt_state.lbuf = avs_writedata[LBUF_BIT];
        end
      end else if (avs_address == csrr_addr(IDX_IRQ_STS)) begin
        if (lane0) begin
          clr = avs_writedata[EV_W-1:0];
        end
      end else if (avs_address == csrr_addr(IDX_IRQ_MSK)) begin
        if (lane0) begin
          nxt_state.irq_msk = avs_writedata[EV_W-1:0];
        end
      end
      // The level readouts are read-only, so writes to them fall through here.
    end

    // A new event in the clearing cycle keeps its bit set.
    nxt_state.irq_sts = (state_ff.irq_sts & ~clr) | rise;
    nxt_state.irq = |(nxt_state.irq_sts & nxt_state.irq_msk);

    // Manual bits only add closures; automatic control still runs when they are low.
    nxt_state.hbuf_sw = high_buf_bypass_auto |
                        (state_ff.ovr_en & state_ff.hbuf & high_buf_disabled);
    nxt_state.lbuf_sw = low_buf_bypass_auto |
                        (state_ff.ovr_en & state_ff.lbuf & low_buf_disabled);
    nxt_state.vref_sw = state_ff.vref_force | vref_low_ohm_pm;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_readdata = state_ff.readdata;
  assign avs_waitrequest = state_ff.waitrequest;
  assign automute_tap_select = state_ff.amute_sel;
  assign high_buf_bypass_sw = state_ff.hbuf_sw;
  assign low_buf_bypass_sw = state_ff.lbuf_sw;
  assign vref_low_ohm_sw = state_ff.vref_sw;
  assign irq = state_ff.irq;

  default clocking regs_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ptp_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_PTP)) |=>
    avs_readdata == {{(DATA_W-LVL_W){1'h0}}, $past(lvl_bus.ptp_sel)})
    else $error("peak-to-peak readout mismatch");

  peak_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_PEAK))
    |=> avs_readdata == {{(DATA_W-LVL_W){1'h0}}, $past(lvl_bus.pk_sel)})
    else $error("peak detector readout mismatch");

  tap_write_a: assert property ((wr_go && lane0 && avs_address == csrr_addr(IDX_AMUTE))
    |=> automute_tap_select == $past(avs_writedata[AMUTE_TAP_BIT]))
    else $error("automute tap select did not follow the write");

  hv_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_AMUTE)) |=>
    avs_readdata[HV_BIT] == $past(high_supply_detect_pin, 3))
    else $error("high supply detect readback wrong");

  ng_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_AMUTE)) |=>
    avs_readdata[NG_BIT] == $past(noise_gate_active))
    else $error("noise gate readback wrong");

  amute_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_AMUTE))
    |=> avs_readdata[AMF_BIT] == $past(analog_mute_flag))
    else $error("analog mute readback wrong");

  dmute_read_a: assert property ((acc && avs_read && avs_address == csrr_addr(IDX_AMUTE))
    |=> avs_readdata[DML_BIT:DMR_BIT] == $past({left_digital_mute_flag, right_digital_mute_flag}))
    else $error("digital mute readback wrong");

  ovr_off_a: assert property (!state_ff.ovr_en |=>
    high_buf_bypass_sw == $past(high_buf_bypass_auto) &&
    low_buf_bypass_sw == $past(low_buf_bypass_auto))
    else $error("manual tie-off bits acted without override");

  hbuf_force_a: assert property ((state_ff.ovr_en && state_ff.hbuf && high_buf_disabled)
    |=> high_buf_bypass_sw)
    else $error("high buffer bypass not closed");

  lbuf_force_a: assert property ((state_ff.ovr_en && state_ff.lbuf && low_buf_disabled)
    |=> low_buf_bypass_sw)
    else $error("low buffer bypass not closed");

  vref_force_a: assert property ((wr_go && lane0 && avs_address == csrr_addr(IDX_BIAS) &&
    avs_writedata[VREFL_BIT]) |-> ##2 vref_low_ohm_sw)
    else $error("vref low-ohm switch not forced");

  rsvd_zero_a: assert property (!avs_waitrequest |-> avs_readdata[DATA_W-1:REG_W] == '0)
    else $error("reserved read bits not zero");

  bus_answer_a: assert property (acc |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after acceptance");

  ev_sticky_a: assert property ((rise != EV_RST) |=>
    ((state_ff.irq_sts & $past(rise)) == $past(rise)))
    else $error("event lost in status register");

  irq_level_a: assert property (irq == |(state_ff.irq_sts & state_ff.irq_msk))
    else $error("interrupt level does not match masked status");

  sts_clear_a: assert property ((wr_go && lane0 && avs_address == csrr_addr(IDX_IRQ_STS))
    |=> (state_ff.irq_sts & $past(avs_writedata[EV_W-1:0] & ~rise)) == EV_RST)
    else $error("written status bits were not cleared");

  vref_auto_a: assert property (!state_ff.vref_force |=>
    vref_low_ohm_sw == $past(vref_low_ohm_pm))
    else $error("vref switch did not follow power management");

  rd_quiet_a: assert property ((acc && avs_read) |=>
    $stable({state_ff.amute_sel, state_ff.ovr_en, state_ff.hbuf, state_ff.lbuf,
             state_ff.vref_force, state_ff.irq_msk}) &&
    (($past(state_ff.irq_sts) & ~state_ff.irq_sts) == EV_RST))
    else $error("read changed register state");

  ro_write_a: assert property ((wr_go && (avs_address == csrr_addr(IDX_PTP) ||
    avs_address == csrr_addr(IDX_PEAK))) |=>
    $stable({state_ff.amute_sel, state_ff.ovr_en, state_ff.hbuf, state_ff.lbuf,
             state_ff.vref_force, state_ff.irq_msk}))
    else $error("write to a readout changed register state");

  ptp_read_c: cover property (acc && avs_read && avs_address == csrr_addr(IDX_PTP));
  ovr_write_c: cover property (wr_go && lane1 && avs_address == csrr_addr(IDX_TIEOFF) &&
    avs_writedata[OVR_EN_BIT]);
  irq_rise_c: cover property ($rose(irq));
  clr_race_c: cover property (wr_go && avs_address == csrr_addr(IDX_IRQ_STS) &&
    ((clr & rise) != EV_RST));
endmodule : csrr_regs
`default_nettype wire

//--- test/csrr_regs_tb.sv
`default_nettype none
module csrr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csrr_pkg::*;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [BE_W-1:0] avs_byteenable = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [LVL_W-1:0] ptp_l = '0;
  logic [LVL_W-1:0] ptp_r = '0;
  logic [LVL_W-1:0] pk_l = '0;
  logic [LVL_W-1:0] pk_r = '0;
  logic alc_l = 1'b0;
  logic alc_r = 1'b0;
  // Flag sources in the status bit order: supply, gate, analog mute, left, right.
  logic [4:0] fl = 5'h00;
  logic [4:0] sw_in = 5'h00;
  logic tap, hsw, lsw, vsw, irq;
  logic [8:0] tq;
  logic [8:0] bq;
  int err_total = 0;
  int tests_run = 0;

  csrr_regs u_csrr_regs (
    .mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .peak_to_peak_level_left(ptp_l), .peak_to_peak_level_right(ptp_r),
    .peak_detect_level_left(pk_l), .peak_detect_level_right(pk_r),
    .alc_left_en(alc_l), .alc_right_en(alc_r),
    .high_supply_detect_pin(fl[4]), .noise_gate_active(fl[3]), .analog_mute_flag(fl[2]),
    .left_digital_mute_flag(fl[1]), .right_digital_mute_flag(fl[0]),
    .high_buf_disabled(sw_in[4]), .low_buf_disabled(sw_in[3]),
    .high_buf_bypass_auto(sw_in[2]), .low_buf_bypass_auto(sw_in[1]),
    .vref_low_ohm_pm(sw_in[0]),
    .automute_tap_select(tap), .high_buf_bypass_sw(hsw), .low_buf_bypass_sw(lsw),
    .vref_low_ohm_sw(vsw), .irq(irq)
  );

  always #2.5 mclk = ~mclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request is held until waitrequest is seen low, then released.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [8:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'h0};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {23'h000000, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      err_total++;
      $display("unexpected bus answer expected waitrequest low seen none");
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [8:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, idx, wd, be, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] idx, input logic [8:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 9'h000, 4'hF, d);
    chk(what, {23'h000000, exp}, d);
  endtask : rdc

  function automatic logic [8:0] pick(input logic [8:0] l, r, input logic le, re);
    if (le && re) begin
      return (l > r) ? l : r;
    end
    return re ? r : l;
  endfunction : pick

  // Manual bits only add to the automatic switch command; the buffer bits act only on a disabled buffer.
  task automatic sw_chk();
    repeat (3) @(posedge mclk);
    #1;
    chk("high bypass", sw_in[2] | (tq[8] & tq[7] & sw_in[4]), hsw);
    chk("low bypass", sw_in[1] | (tq[8] & tq[6] & sw_in[3]), lsw);
    chk("vref switch", bq[0] | sw_in[0], vsw);
  endtask : sw_chk

  initial begin
    void'($urandom(18159));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rdc("bias reset", IDX_BIAS, 9'h000);
    rdc("amute reset", IDX_AMUTE, 9'h000);
    rdc("tieoff reset", IDX_TIEOFF, 9'h000);
    rdc("mask reset", IDX_IRQ_MSK, 9'h000);
    chk("tap reset", 1'b0, tap);
    $display("reset values done");

    wr(IDX_BIAS, 9'h1FF, 4'hF);
    rdc("bias fields", IDX_BIAS, 9'h001);
    wr(IDX_TIEOFF, 9'h1FF, 4'h1);
    rdc("tieoff lane", IDX_TIEOFF, 9'h0C0);
    wr(IDX_TIEOFF, 9'h1FF, 4'hF);
    rdc("tieoff fields", IDX_TIEOFF, 9'h1C0);
    wr(8'h52, 9'h1FF, 4'hF);
    rdc("unmapped", 8'h52, 9'h000);
    for (int v = 1; v >= 0; v--) begin
      wr(IDX_AMUTE, {3'h0, v[0], 5'h1F}, 4'hF);
      rdc("amute fields", IDX_AMUTE, {3'h0, v[0], 5'h00});
      chk("tap out", v[0], tap);
    end
    $display("register fields done");

    for (int i = 0; i < 24; i++) begin
      @(posedge mclk);
      ptp_l <= 9'($urandom);
      ptp_r <= (i == 0) ? 9'h1FF : 9'($urandom);
      pk_l <= (i == 1) ? 9'h1FF : 9'($urandom);
      pk_r <= 9'($urandom);
      {alc_l, alc_r} <= 2'(i);
      wr(IDX_PTP, 9'($urandom), 4'hF);
      wr(IDX_PEAK, 9'($urandom), 4'hF);
      rdc("p2p level", IDX_PTP, pick(ptp_l, ptp_r, alc_l, alc_r));
      rdc("peak level", IDX_PEAK, pick(pk_l, pk_r, alc_l, alc_r));
    end
    $display("level readouts done");

    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      fl <= (i == 0) ? 5'h1F : 5'($urandom);
      repeat (3) @(posedge mclk);
      rdc("status flags", IDX_AMUTE, {4'h0, fl});
    end
    $display("status flags done");

    for (int i = 0; i < 24; i++) begin
      @(posedge mclk);
      sw_in <= (i == 0) ? 5'h18 : 5'($urandom);
      tq = (i == 0) ? 9'h1C0 : 9'($urandom);
      bq = 9'($urandom);
      wr(IDX_TIEOFF, tq, 4'hF);
      wr(IDX_BIAS, bq, 4'hF);
      sw_chk();
    end
    $display("tie-off switches done");

    // A flag that stays high after the clear must not set its bit again.
    @(posedge mclk);
    fl <= 5'h00;
    repeat (3) @(posedge mclk);
    wr(IDX_IRQ_STS, 9'h01F, 4'hF);
    rdc("irq status clear", IDX_IRQ_STS, 9'h000);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      fl <= 5'(1 << i);
      repeat (5) @(posedge mclk);
      rdc("irq status", IDX_IRQ_STS, 9'(1 << i));
      chk("irq masked", 1'b0, irq);
      wr(IDX_IRQ_MSK, 9'(1 << i), 4'hF);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq raised", 1'b1, irq);
      wr(IDX_IRQ_STS, 9'h01F, 4'hF);
      rdc("irq cleared", IDX_IRQ_STS, 9'h000);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq dropped", 1'b0, irq);
      wr(IDX_IRQ_MSK, 9'h000, 4'hF);
    end
    $display("interrupts done");
    stop_test();
  end
endmodule : csrr_regs_tb
`default_nettype wire
